// [spcf_ctrl.sv]
// Serial peripheral controller: control fields, shift engine, interrupt
// What this block does
// - Queue master: idle and drained clears run
// - Master byte swap inserts byte gaps of gap length
// - Byte swap only for 16, 24, 32 bits
// - Role bit: 0 master, 1 slave
// - Interrupt only while enable bit set
// - Unit flag set on done, write-one clears
// - Master word spacing is gap plus half
// - Idle level bit sets idle clock level
// - Bit order bit selects LSB first
// - Word length field sets bits per word
// - Length code 0 is 32, 8..31 literal
// - Queue master: data write sets run
// - Non-queue run write starts or readies
`timescale 1ns/10ps
module spcf_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire spcf_pkg::spcf_bus_t bus,
    output logic [31:0] rdData,
    // Serial pins
    input wire logic sclkIn,
    input wire logic sdi,
    input wire logic ssInN,
    output spcf_pkg::spcf_pins_t pins,
    // Interrupt
    output logic irq
);
    import spcf_pkg::*;

    // Control fields
    logic run_ff, nxt_run;
    logic [4:0] lenSel_ff, nxt_lenSel;
    logic lsbFirst_ff, nxt_lsbFirst;
    logic idleHigh_ff, nxt_idleHigh;
    logic [3:0] gap_ff, nxt_gap;
    logic ie_ff, nxt_ie;
    logic slave_ff, nxt_slave;
    logic swap_ff, nxt_swap;
    logic queue_ff, nxt_queue;
    logic [7:0] div_ff, nxt_div;
    logic [EV_W-1:0] ist_ff, nxt_ist;
    logic [EV_W-1:0] ien_ff, nxt_ien;
    logic [31:0] txHold_ff, nxt_txHold;
    logic holdFull_ff, nxt_holdFull;
    logic [31:0] rxWord_ff, nxt_rxWord;
    logic [31:0] rdData_ff, nxt_rdData;
    logic irq_ff, nxt_irq;
    // Engine state
    spcf_state_t state_ff, nxt_state;
    logic [7:0] hcnt_ff, nxt_hcnt;
    logic [4:0] gcnt_ff, nxt_gcnt;
    logic phase_ff, nxt_phase;
    logic [5:0] bitCnt_ff, nxt_bitCnt;
    logic [31:0] shTx_ff, nxt_shTx;
    logic [31:0] shRx_ff, nxt_shRx;
    spcf_pins_t pins_ff, nxt_pins;
    logic sclkPrev_ff, nxt_sclkPrev;
    // Engine events toward the register group
    logic wordDone;
    logic takeHold;
    logic drained;
    // Synchronised pins
    logic [2:0] pinSync;
    logic sclkS, sdiS, ssS;

    // Word length code to bit count
    function automatic logic [5:0] wordBits(input logic [4:0] code);
        if (code == 5'h00) begin
            wordBits = 6'h20;
        end else if (code < 5'h08) begin
            wordBits = 6'h08;
        end else begin
            wordBits = {1'b0, code};
        end
    endfunction

    // Lengths that allow byte swap
    function automatic logic swapOk(input logic [5:0] bits);
        swapOk = (bits == 6'h10) || (bits == 6'h18) || (bits == 6'h20);
    endfunction

    // Reverse byte order within the word
    function automatic logic [31:0] byteSwap(input logic [31:0] w, input logic [5:0] bits);
        if (bits == 6'h10) begin
            byteSwap = {16'h0000, w[7:0], w[15:8]};
        end else if (bits == 6'h18) begin
            byteSwap = {8'h00, w[7:0], w[15:8], w[23:16]};
        end else begin
            byteSwap = {w[7:0], w[15:8], w[23:16], w[31:24]};
        end
    endfunction

    // Bit presented on the data line
    function automatic logic outBit(input logic [31:0] sh, input logic lsb,
                                    input logic [5:0] bits);
        outBit = lsb ? sh[0] : sh[5'(bits - 6'h01)];
    endfunction

    // Receive shift by bit order
    function automatic logic [31:0] shiftIn(input logic [31:0] rx, input logic b,
                                            input logic lsb, input logic [5:0] bits);
        if (lsb) begin
            shiftIn = (rx >> 1) | (32'(b) << 5'(bits - 6'h01));
        end else begin
            shiftIn = {rx[30:0], b};
        end
    endfunction

    // Pin synchronisers
    spcf_sync #(.W(3)) uSync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({sclkIn, sdi, ssInN}),
        .syncOut(pinSync)
    );
    assign sclkS = pinSync[2];
    assign sdiS = pinSync[1];
    assign ssS = pinSync[0];

    // Shift engine, master and slave
    always_comb begin
        logic [5:0] bits;
        logic swapOn;
        logic [31:0] loadVal;
        logic [31:0] shifted;
        logic tick;
        logic lead;
        logic trail;
        bits = wordBits(lenSel_ff);
        swapOn = swap_ff && swapOk(bits);
        loadVal = swapOn ? byteSwap(txHold_ff, bits) : txHold_ff;
        shifted = lsbFirst_ff ? (shTx_ff >> 1) : (shTx_ff << 1);
        tick = (hcnt_ff == 8'h00);
        lead = (sclkS != sclkPrev_ff) && (sclkS != idleHigh_ff);
        trail = (sclkS != sclkPrev_ff) && (sclkS == idleHigh_ff);
        nxt_state = state_ff;
        nxt_hcnt = tick ? div_ff : 8'(hcnt_ff - 8'h01);
        nxt_gcnt = gcnt_ff;
        nxt_phase = phase_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_shTx = shTx_ff;
        nxt_shRx = shRx_ff;
        nxt_rxWord = rxWord_ff;
        nxt_pins = pins_ff;
        nxt_sclkPrev = sclkS;
        wordDone = 1'b0;
        takeHold = 1'b0;
        drained = 1'b0;
        nxt_pins.sclkOeN = slave_ff;
        if (slave_ff) begin
            // slave relies on select held through gaps
            nxt_pins.ssOutN = 1'b1;
            if (!run_ff || ssS) begin
                nxt_state = SP_IDLE;
                nxt_pins.sdoOeN = 1'b1;
                nxt_bitCnt = 6'h00;
            end else if (state_ff == SP_IDLE) begin
                nxt_state = SP_RUN;
                takeHold = holdFull_ff;
                nxt_shTx = holdFull_ff ? loadVal : 32'h0000_0000;
                nxt_shRx = 32'h0000_0000;
                nxt_pins.sdo = holdFull_ff ? outBit(loadVal, lsbFirst_ff, bits) : 1'b0;
                nxt_pins.sdoOeN = 1'b0;
            end else if (lead) begin
                nxt_shRx = shiftIn(shRx_ff, sdiS, lsbFirst_ff, bits);
            end else if (trail) begin
                nxt_bitCnt = 6'(bitCnt_ff + 6'h01);
                nxt_shTx = shifted;
                nxt_pins.sdo = outBit(shifted, lsbFirst_ff, bits);
                if (6'(bitCnt_ff + 6'h01) == bits) begin
                    wordDone = 1'b1;
                    nxt_rxWord = shRx_ff;
                    nxt_bitCnt = 6'h00;
                    nxt_shRx = 32'h0000_0000;
                    takeHold = holdFull_ff;
                    nxt_shTx = holdFull_ff ? loadVal : 32'h0000_0000;
                    nxt_pins.sdo = holdFull_ff ? outBit(loadVal, lsbFirst_ff, bits) : 1'b0;
                end
            end
        end else begin
            nxt_pins.sdoOeN = 1'b0;
            case (state_ff)
                SP_IDLE: begin
                    nxt_pins.sclkOut = idleHigh_ff;
                    nxt_pins.ssOutN = 1'b1;
                    nxt_hcnt = div_ff;
                    if (run_ff && holdFull_ff) begin
                        takeHold = 1'b1;
                        nxt_shTx = loadVal;
                        nxt_shRx = 32'h0000_0000;
                        nxt_bitCnt = 6'h00;
                        // first bit by order and length
                        nxt_pins.sdo = outBit(loadVal, lsbFirst_ff, bits);
                        nxt_pins.ssOutN = 1'b0;
                        nxt_gcnt = 5'h00;
                        nxt_state = SP_GAP;
                    end
                end
                SP_GAP: begin
                    if (tick) begin
                        if (gcnt_ff == 5'h00) begin
                            nxt_pins.sclkOut = !idleHigh_ff;
                            nxt_shRx = shiftIn(shRx_ff, sdiS, lsbFirst_ff, bits);
                            nxt_phase = 1'b1;
                            nxt_state = SP_RUN;
                        end else begin
                            nxt_gcnt = 5'(gcnt_ff - 5'h01);
                        end
                    end
                end
                SP_RUN: begin
                    if (tick && !phase_ff) begin
                        nxt_pins.sclkOut = !idleHigh_ff;
                        nxt_shRx = shiftIn(shRx_ff, sdiS, lsbFirst_ff, bits);
                        nxt_phase = 1'b1;
                    end else if (tick) begin
                        nxt_pins.sclkOut = idleHigh_ff;
                        nxt_phase = 1'b0;
                        nxt_shTx = shifted;
                        nxt_pins.sdo = outBit(shifted, lsbFirst_ff, bits);
                        nxt_bitCnt = 6'(bitCnt_ff + 6'h01);
                        if (6'(bitCnt_ff + 6'h01) == bits) begin
                            wordDone = 1'b1;
                            nxt_rxWord = shRx_ff;
                            // next word after gap plus half
                            if (queue_ff && holdFull_ff) begin
                                takeHold = 1'b1;
                                nxt_shTx = loadVal;
                                nxt_shRx = 32'h0000_0000;
                                nxt_bitCnt = 6'h00;
                                nxt_pins.sdo = outBit(loadVal, lsbFirst_ff, bits);
                                nxt_gcnt = {gap_ff, 1'b0};
                                nxt_state = SP_GAP;
                            end else begin
                                drained = queue_ff;
                                nxt_state = SP_IDLE;
                            end
                        end else if (swapOn && gap_ff != 4'h0 &&
                                     nxt_bitCnt[2:0] == 3'h0) begin
                            nxt_gcnt = {gap_ff, 1'b0};
                            nxt_state = SP_GAP;
                        end
                    end
                end
                default: begin
                    nxt_state = SP_IDLE;
                end
            endcase
        end
    end

    // Register writes, reads and interrupt
    always_comb begin
        nxt_run = run_ff;
        nxt_lenSel = lenSel_ff;
        nxt_lsbFirst = lsbFirst_ff;
        nxt_idleHigh = idleHigh_ff;
        nxt_gap = gap_ff;
        nxt_ie = ie_ff;
        nxt_slave = slave_ff;
        nxt_swap = swap_ff;
        nxt_queue = queue_ff;
        nxt_div = div_ff;
        nxt_ist = ist_ff;
        nxt_ien = ien_ff;
        nxt_txHold = txHold_ff;
        nxt_holdFull = holdFull_ff && !takeHold;
        nxt_rdData = 32'h0000_0000;
        if (!slave_ff && queue_ff && state_ff == SP_IDLE && !holdFull_ff) begin
            nxt_run = 1'b0;
        end
        if (!slave_ff && !queue_ff && wordDone) begin
            nxt_run = 1'b0;
        end
        if (bus.wr) begin
            case (bus.addr)
                CTRL_OFS: begin
                    if (!queue_ff && bus.wdata[RUN_BIT]) begin
                        nxt_run = 1'b1;
                    end
                    nxt_lenSel = bus.wdata[LEN_MSB:LEN_LSB];
                    nxt_lsbFirst = bus.wdata[LSB_BIT];
                    nxt_idleHigh = bus.wdata[IDLE_BIT];
                    nxt_gap = bus.wdata[GAP_MSB:GAP_LSB];
                    nxt_ie = bus.wdata[IE_BIT];
                    nxt_slave = bus.wdata[SLAVE_BIT];
                    nxt_swap = bus.wdata[SWAP_BIT];
                    nxt_queue = bus.wdata[QUEUE_BIT];
                    if (bus.wdata[FLAG_BIT]) begin
                        nxt_ist[EV_UNIT] = 1'b0;
                    end
                end
                TXD_OFS: begin
                    nxt_txHold = bus.wdata;
                    nxt_holdFull = 1'b1;
                    if (queue_ff && !slave_ff) begin
                        nxt_run = 1'b1;
                    end
                end
                DIV_OFS: nxt_div = bus.wdata[7:0];
                ICLR_OFS: nxt_ist = nxt_ist & ~bus.wdata[EV_W-1:0];
                IEN_OFS: nxt_ien = bus.wdata[EV_W-1:0];
                default: begin
                end
            endcase
        end
        if (wordDone) begin
            nxt_ist[EV_UNIT] = 1'b1;
        end
        if (drained) begin
            nxt_ist[EV_EMPTY] = 1'b1;
        end
        nxt_irq = ie_ff && |(ist_ff & ien_ff);
        if (bus.rd) begin
            case (bus.addr)
                CTRL_OFS: begin
                    nxt_rdData[RUN_BIT] = slave_ff ? 1'b1 : run_ff;
                    nxt_rdData[LEN_MSB:LEN_LSB] = lenSel_ff;
                    nxt_rdData[LSB_BIT] = lsbFirst_ff;
                    nxt_rdData[IDLE_BIT] = idleHigh_ff;
                    nxt_rdData[GAP_MSB:GAP_LSB] = gap_ff;
                    nxt_rdData[FLAG_BIT] = ist_ff[EV_UNIT];
                    nxt_rdData[IE_BIT] = ie_ff;
                    nxt_rdData[SLAVE_BIT] = slave_ff;
                    nxt_rdData[SWAP_BIT] = swap_ff;
                    nxt_rdData[QUEUE_BIT] = queue_ff;
                    nxt_rdData[TXE_BIT] = !holdFull_ff;
                    nxt_rdData[TXF_BIT] = holdFull_ff;
                end
                RXD_OFS: nxt_rdData = rxWord_ff;
                DIV_OFS: nxt_rdData[7:0] = div_ff;
                IST_OFS: nxt_rdData[EV_W-1:0] = ist_ff;
                IEN_OFS: nxt_rdData[EV_W-1:0] = ien_ff;
                default: nxt_rdData = 32'h0000_0000;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
            lenSel_ff <= LEN_RST;
            lsbFirst_ff <= 1'b0;
            idleHigh_ff <= 1'b0;
            gap_ff <= GAP_RST;
            ie_ff <= 1'b0;
            slave_ff <= 1'b0;
            swap_ff <= 1'b0;
            queue_ff <= 1'b0;
            div_ff <= DIV_RST;
            ist_ff <= '0;
            ien_ff <= '0;
            txHold_ff <= 32'h0000_0000;
            holdFull_ff <= 1'b0;
            rxWord_ff <= 32'h0000_0000;
            rdData_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            state_ff <= SP_IDLE;
            hcnt_ff <= 8'h00;
            gcnt_ff <= 5'h00;
            phase_ff <= 1'b0;
            bitCnt_ff <= 6'h00;
            shTx_ff <= 32'h0000_0000;
            shRx_ff <= 32'h0000_0000;
            pins_ff <= PINS_RST;
            sclkPrev_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            lenSel_ff <= nxt_lenSel;
            lsbFirst_ff <= nxt_lsbFirst;
            idleHigh_ff <= nxt_idleHigh;
            gap_ff <= nxt_gap;
            ie_ff <= nxt_ie;
            slave_ff <= nxt_slave;
            swap_ff <= nxt_swap;
            queue_ff <= nxt_queue;
            div_ff <= nxt_div;
            ist_ff <= nxt_ist;
            ien_ff <= nxt_ien;
            txHold_ff <= nxt_txHold;
            holdFull_ff <= nxt_holdFull;
            rxWord_ff <= nxt_rxWord;
            rdData_ff <= nxt_rdData;
            irq_ff <= nxt_irq;
            state_ff <= nxt_state;
            hcnt_ff <= nxt_hcnt;
            gcnt_ff <= nxt_gcnt;
            phase_ff <= nxt_phase;
            bitCnt_ff <= nxt_bitCnt;
            shTx_ff <= nxt_shTx;
            shRx_ff <= nxt_shRx;
            pins_ff <= nxt_pins;
            sclkPrev_ff <= nxt_sclkPrev;
        end
    end

    // Outputs straight from flip-flops
    assign rdData = rdData_ff;
    assign pins = pins_ff;
    assign irq = irq_ff;
endmodule

// [spcf_pkg.sv]
// Shared constants, state codes and carrier types of the serial control block
package spcf_pkg;
    // Register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TXD_OFS = 8'h04;
    localparam logic [7:0] RXD_OFS = 8'h08;
    localparam logic [7:0] DIV_OFS = 8'h0C;
    localparam logic [7:0] IST_OFS = 8'h10;
    localparam logic [7:0] ICLR_OFS = 8'h14;
    localparam logic [7:0] IEN_OFS = 8'h18;
    // Field positions of the control status word
    localparam int RUN_BIT = 0;
    localparam int LEN_LSB = 3;
    localparam int LEN_MSB = 7;
    localparam int LSB_BIT = 10;
    localparam int IDLE_BIT = 11;
    localparam int GAP_LSB = 12;
    localparam int GAP_MSB = 15;
    localparam int FLAG_BIT = 16;
    localparam int IE_BIT = 17;
    localparam int SLAVE_BIT = 18;
    localparam int SWAP_BIT = 19;
    localparam int QUEUE_BIT = 21;
    localparam int TXE_BIT = 26;
    localparam int TXF_BIT = 27;
    // Values after reset
    localparam logic [3:0] GAP_RST = 4'h3;
    localparam logic [4:0] LEN_RST = 5'h08;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [4:0] PINS_RST = 5'h0B;
    // Interrupt event bits
    localparam int EV_UNIT = 0;
    localparam int EV_EMPTY = 1;
    localparam int EV_W = 2;
    // Engine states, Gray along idle, gap, run
    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_GAP = 2'b01,
        SP_RUN = 2'b11
    } spcf_state_t;
    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } spcf_bus_t;
    // Serial pins driven by the block
    typedef struct packed {
        logic sclkOut;
        logic sclkOeN;
        logic sdo;
        logic sdoOeN;
        logic ssOutN;
    } spcf_pins_t;
endpackage

// [spcf_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module spcf_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous inputs and synchronised copies
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;

    if (W < 1) begin : gWidthCheck
        $error("spcf_sync width must be at least one");
    end

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule

// [spcf_ctrl_props.sv]
// Port-level checker for the serial control block
`timescale 1ns/10ps
module spcf_ctrl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire spcf_pkg::spcf_bus_t bus,
    input wire logic [31:0] rdData,
    // Serial pins
    input wire logic sclkIn,
    input wire logic sdi,
    input wire logic ssInN,
    input wire spcf_pkg::spcf_pins_t pins,
    // Interrupt
    input wire logic irq
);
    import spcf_pkg::*;
    logic [7:0] nEdge_ff;
    logic clkSeen_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Serial clock edges counted within a frame
    always_ff @(posedge clk) begin
        clkSeen_ff <= pins.sclkOut;
        if (!rst_n || pins.ssOutN) begin
            nEdge_ff <= 8'h00;
        end else if (pins.sclkOut != clkSeen_ff) begin
            nEdge_ff <= nEdge_ff + 8'h01;
        end
    end
    property p_rd_zero;
        !bus.rd |=> rdData == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
    property p_rd_void;
        bus.rd && (bus.addr == ICLR_OFS || bus.addr > IEN_OFS) |=> rdData == 32'h0;
    endproperty
    a_rd_void: assert property (p_rd_void) else $error("void address read");
    property p_sclk_quiet;
        pins.ssOutN && $past(pins.ssOutN) && !$past(bus.wr) && !$past(bus.wr, 2)
            |-> $stable(pins.sclkOut);
    endproperty
    a_sclk_quiet: assert property (p_sclk_quiet) else $error("clock moved while idle");
    property p_ss_oe;
        !pins.ssOutN |-> !pins.sclkOeN && !pins.sdoOeN;
    endproperty
    a_ss_oe: assert property (p_ss_oe) else $error("select without drive");
    property p_slave_oe;
        pins.sclkOeN && $past(pins.sclkOeN) && !pins.sdoOeN
            |-> !$past(ssInN, 3) || !$past(ssInN, 4);
    endproperty
    a_slave_oe: assert property (p_slave_oe) else $error("slave drove unselected");
    property p_irq_fall;
        $fell(irq) |-> $past(bus.wr) || $past(bus.wr, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell with no write");
    property p_ss_word;
        $fell(pins.ssOutN) |=> (!pins.ssOutN) [*8];
    endproperty
    a_ss_word: assert property (p_ss_word) else $error("frame too short");
    property p_edge_count;
        $rose(pins.ssOutN) |-> nEdge_ff[0] == 1'b0 && nEdge_ff >= 8'h10;
    endproperty
    a_edge_count: assert property (p_edge_count) else $error("bad clock edge count");
endmodule
bind spcf_ctrl spcf_ctrl_props chk_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdData(rdData),
    .sclkIn(sclkIn), .sdi(sdi), .ssInN(ssInN), .pins(pins), .irq(irq));

// [spcf_peer.sv]
// Behavioural serial slave on the far side of the block
`timescale 1ns/10ps
module spcf_peer (
    // Serial bus
    input wire logic sclk,
    input wire logic ssN,
    input wire logic mosi,
    input wire logic idle,
    // Reply word and captured bits
    input wire logic [31:0] reply,
    output logic miso,
    output logic [31:0] got
);
    int pos;
    initial begin
        miso = 1'b0;
        got = 32'h0;
        pos = 0;
    end
    // Capture on leading edge, next reply bit on trailing
    always @(sclk) begin
        if (!ssN && sclk != idle) begin
            got = {got[30:0], mosi};
        end else if (!ssN) begin
            pos = pos + 1;
            miso = reply[31 - (pos % 32)];
        end
    end
    // Select starts the reply; release inverts the line
    always @(ssN) begin
        pos = 0;
        miso = ssN ? ~miso : reply[31];
    end
endmodule

// [spcf_ctrl_tb_top.sv]
// Self-checking bench for the serial control block
`timescale 1ns/10ps
module spcf_ctrl_tb_top;
    import spcf_pkg::*;
    localparam logic [31:0] F_LSB = 32'h0000_0400;
    localparam logic [31:0] F_IDLE = 32'h0000_0800;
    localparam logic [31:0] F_FLAG = 32'h0001_0000;
    localparam logic [31:0] F_IRQ = 32'h0002_0000;
    localparam logic [31:0] F_SLV = 32'h0004_0000;
    localparam logic [31:0] F_SWP = 32'h0008_0000;
    localparam logic [31:0] F_Q = 32'h0020_0000;
    localparam logic [7:0] SLV_PAT = 8'h4E;
    logic clk, rst_n, sclkIn, ssInN, tbSdi, miso, sdi, irq, slaveMode, idleLvl, lastClk;
    logic [31:0] rdData, got, gapMax, sinceEdge;
    spcf_bus_t bus;
    spcf_pins_t pins;
    int n_mismatch, n_compared;
    assign sdi = slaveMode ? tbSdi : miso;
    spcf_ctrl dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdData(rdData), .sclkIn(sclkIn),
        .sdi(sdi), .ssInN(ssInN), .pins(pins), .irq(irq));
    spcf_peer peer_u (.sclk(pins.sclkOut), .ssN(pins.ssOutN), .mosi(pins.sdo), .idle(idleLvl),
        .reply(32'hC1E2_4B7D), .miso(miso), .got(got));
    // Clock
    always #2.5 clk = ~clk;
    // Longest spell between serial clock edges within a frame
    always @(posedge clk) begin
        lastClk <= pins.sclkOut;
        if (pins.ssOutN) begin
            sinceEdge <= 32'h0;
        end else if (pins.sclkOut != lastClk) begin
            gapMax <= (sinceEdge > gapMax) ? sinceEdge : gapMax;
            sinceEdge <= 32'h1;
        end else begin
            sinceEdge <= sinceEdge + 32'h1;
        end
    end
    function automatic logic [31:0] cfg(input logic [4:0] len, input logic [3:0] gap,
            input logic [31:0] fl);
        cfg = fl | {16'h0, gap, 4'h0, len, 3'h0};
    endfunction
    task automatic print_verdict();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus <= '{1'b0, 1'b0, a, d};
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        bus <= '{1'b0, 1'b0, a, 32'h0};
        @(posedge clk);
        d = rdData;
    endtask
    task automatic waitIdle();
        logic [31:0] v;
        v = 32'h1;
        for (int i = 0; i < 2000 && v[0] !== 1'b0; i++) begin
            rd(CTRL_OFS, v);
        end
        if (v[0] !== 1'b0) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic t_regs();
        logic [31:0] v;
        rd(CTRL_OFS, v);
        check(v & 32'h000F_FCF8, 32'h0000_3040);
        rd(8'h20, v);
        check(v, 32'h0);
        wr(DIV_OFS, 32'hFFFF_FF0F);
        rd(DIV_OFS, v);
        check(v, 32'h0F);
        wr(IEN_OFS, 32'h1);
    endtask
    task automatic t_master(input logic [4:0] len, input logic [31:0] fl, input logic [31:0] tx,
            input logic [31:0] exGot, input logic [31:0] mask, input logic [31:0] exRx);
        logic [31:0] v;
        idleLvl <= fl[11];
        wr(CTRL_OFS, cfg(len, 4'h0, fl));
        repeat (2) @(posedge clk);
        check({31'h0, pins.sclkOut}, {31'h0, fl[11]});
        wr(TXD_OFS, tx);
        wr(CTRL_OFS, cfg(len, 4'h0, fl | 32'h1));
        waitIdle();
        check(got & mask, exGot);
        rd(RXD_OFS, v);
        check(v, exRx);
        rd(CTRL_OFS, v);
        check(v & F_FLAG, F_FLAG);
        check({31'h0, irq}, {31'h0, fl[17]});
        wr(CTRL_OFS, cfg(len, 4'h0, fl | F_FLAG));
        rd(CTRL_OFS, v);
        check(v & F_FLAG, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask
    task automatic t_queue();
        logic [31:0] v;
        gapMax = 32'h0;
        wr(CTRL_OFS, cfg(5'h08, 4'h1, F_Q));
        wr(TXD_OFS, 32'h3C);
        rd(CTRL_OFS, v);
        check(v & 32'h1, 32'h1);
        for (int i = 0; i < 500 && v[TXF_BIT] !== 1'b0; i++) begin
            rd(CTRL_OFS, v);
        end
        check(v & 32'h0800_0000, 32'h0);
        wr(TXD_OFS, 32'h5A);
        waitIdle();
        check(got & 32'hFFFF, 32'h3C5A);
        check(gapMax, 32'd48);
        rd(CTRL_OFS, v);
        check(v & 32'h0400_0001, 32'h0400_0000);
        rd(IST_OFS, v);
        check(v & 32'h2, 32'h2);
        wr(ICLR_OFS, 32'h3);
        rd(IST_OFS, v);
        check(v, 32'h0);
    endtask
    task automatic t_swap();
        gapMax = 32'h0;
        wr(CTRL_OFS, cfg(5'h10, 4'h2, F_SWP));
        wr(TXD_OFS, 32'hAB12);
        wr(CTRL_OFS, cfg(5'h10, 4'h2, F_SWP | 32'h1));
        waitIdle();
        check(got & 32'hFFFF, 32'h12AB);
        check(gapMax, 32'd80);
        wr(CTRL_OFS, cfg(5'h08, 4'h2, F_SWP));
        wr(TXD_OFS, 32'hC3);
        wr(CTRL_OFS, cfg(5'h08, 4'h2, F_SWP | 32'h1));
        waitIdle();
        check(got & 32'hFF, 32'hC3);
    endtask
    task automatic t_slave();
        logic [31:0] v;
        logic [7:0] seen;
        logic oe;
        oe = 1'b0;
        slaveMode <= 1'b1;
        wr(CTRL_OFS, cfg(5'h08, 4'h0, F_SLV));
        wr(TXD_OFS, 32'h96);
        wr(CTRL_OFS, cfg(5'h08, 4'h0, F_SLV | 32'h1));
        rd(CTRL_OFS, v);
        check(v & 32'h1, 32'h1);
        // Select held low for the whole word
        ssInN <= 1'b0;
        tbSdi <= SLV_PAT[7];
        for (int i = 7; i >= 0; i--) begin
            repeat (16) @(posedge clk);
            sclkIn <= 1'b1;
            seen[i] = pins.sdo;
            oe = oe | pins.sdoOeN;
            repeat (16) @(posedge clk);
            sclkIn <= 1'b0;
            tbSdi <= (i > 0) ? SLV_PAT[i - 1] : ~tbSdi;
        end
        repeat (16) @(posedge clk);
        ssInN <= 1'b1;
        repeat (8) @(posedge clk);
        check({24'h0, seen}, 32'h96);
        check({31'h0, oe}, 32'h0);
        rd(RXD_OFS, v);
        check(v, {24'h0, SLV_PAT});
    endtask
    // Reset, then the scenarios in turn
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        bus = '0;
        sclkIn = 1'b0;
        ssInN = 1'b1;
        tbSdi = 1'b0;
        slaveMode = 1'b0;
        idleLvl = 1'b0;
        lastClk = 1'b0;
        gapMax = 32'h0;
        sinceEdge = 32'h0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_master(5'h08, F_IRQ, 32'h2D, 32'h2D, 32'hFF, 32'hC1);
        t_master(5'h08, F_LSB | F_IDLE, 32'h2D, 32'hB4, 32'hFF, 32'h83);
        t_master(5'h00, F_IRQ, 32'h1234_5678, 32'h1234_5678, 32'hFFFF_FFFF, 32'hC1E2_4B7D);
        t_master(5'h1F, F_IRQ, 32'h1234_5678, 32'h1234_5678, 32'h7FFF_FFFF, 32'h60F1_25BE);
        t_queue();
        t_swap();
        t_slave();
        print_verdict();
    end
endmodule
